// >>> bsn_regs.sv
// Functional notes
// R1: each bit of 04h bits 5:0 forces its LED output to full duty.
// R2: 11-bit temperature: top eight bits at 05h, low three in 06h bits 7:5.
// R3: reading 05h latches the low bits of that same sample.
// R4: host reads 05h before 06h.
// R5: 72h bit 7 reads 0 while an operation runs, 1 when idle.
// R6: host sets the unlock bit before asking for burn or load.
// R7: burn bit starts copying shadow registers to memory, about 200 ms.
// R8: load bit copies memory contents back into the shadow registers.
// R9: burn sequence: 05h to 01h, fill a0h-a7h, 04h, 02h, wait, 00h.
// R10: load sequence: 05h to 01h, 04h, 01h to 72h, wait, 00h.
// R11: shadow register writes act on the device at once.
// R12: unburned shadow contents are lost at power removal.
// R13: at startup memory contents are loaded into the shadow registers.
// R14: burn or load without prior unlock is ignored; ready stays high.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bsn_regs #(
	parameter int unsigned NVM_OP_CYCLES = bsn_pkg::NVM_OP_CYCLES,
	parameter logic [7:0]  IDENT_VALUE   = 8'h5a // arbitrary value
) (
	input  wire logic        clk,        // 40 MHz system clock
	input  wire logic        sys_rst,    // sync reset, active high
	input  wire logic        clkEn,      // freezes all state when low
	input  wire logic [7:0]  regAddr,    // register address
	input  wire logic [7:0]  regWdata,   // write data
	input  wire logic        regWr,      // write strobe
	input  wire logic        regRd,      // read strobe
	output logic      [7:0]  regRdata,   // read data, cycle after regRd
	input  wire logic [10:0] tempSample, // live sensor reading
	input  wire logic [5:0]  pwmIn,      // per-output pwm from dimmer
	output logic      [5:0]  ledDrive,   // per-output drive enable
	output logic      [63:0] cfgImage,   // shadow bytes a0h..a7h
	output logic             nvmIdle     // store ready
);
	bsn_nvm_if nif ();

	logic       wr;
	logic       rd;
	logic       ctlWr;
	logic       armed;
	logic       burnReq;
	logic       loadReq;
	logic [7:0] rdValue;
	logic [7:0] tempHiNow;
	logic [2:0] tempLoNow;

	logic [5:0] forceQ, forceD;
	logic       unlockQ, unlockD;
	logic       burnQ, burnD;
	logic       loadQ, loadD;
	logic [2:0] tempLowQ, tempLowD;
	logic [7:0] rdDataQ, rdDataD;
	logic [5:0] ledDriveQ, ledDriveD;
	logic [7:0] shadowQ [bsn_pkg::SHADOW_COUNT];
	logic [7:0] shadowD [bsn_pkg::SHADOW_COUNT];

	// strobes only count while the block is enabled
	assign wr        = clkEn & regWr;
	assign rd        = clkEn & regRd;
	assign ctlWr     = wr && (regAddr == bsn_pkg::ADDR_NVM_CTL);
	assign tempHiNow = tempSample[bsn_pkg::TEMP_W-1:bsn_pkg::TEMP_HI_LSB];
	assign tempLoNow = tempSample[bsn_pkg::TEMP_LO_W-1:0];

	// unlock must already be stored; the same write may clear it
	assign armed   = ctlWr && unlockQ && !nif.busy; // R14
	assign burnReq = armed && regWdata[bsn_pkg::BURN_POS]; // R7
	assign loadReq = armed && regWdata[bsn_pkg::LOAD_POS]
		&& !regWdata[bsn_pkg::BURN_POS]; // R8

	assign nif.startBurn = burnReq;
	assign nif.startLoad = loadReq;
	assign nif.image     = cfgImage;

	bsn_nvm_store #(
		.OP_CYCLES (NVM_OP_CYCLES)
	) u_store (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.nif     (nif.store)
	);

	// control bits, force bits and temperature latch
	always_comb begin
		forceD   = forceQ;
		unlockD  = unlockQ;
		burnD    = burnQ;
		loadD    = loadQ;
		tempLowD = tempLowQ;
		if (wr && regAddr == bsn_pkg::ADDR_FORCE) begin
			forceD = regWdata[bsn_pkg::FORCE_W-1:0]; // R1
		end
		if (ctlWr) begin
			unlockD = regWdata[bsn_pkg::UNLOCK_POS];
			burnD   = regWdata[bsn_pkg::BURN_POS];
			loadD   = regWdata[bsn_pkg::LOAD_POS];
		end
		// catching the low bits on the high read keeps the pair coherent
		if (rd && regAddr == bsn_pkg::ADDR_TEMP_HI) begin
			tempLowD = tempLoNow; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			forceQ   <= bsn_pkg::FORCE_RST;
			unlockQ  <= 1'b0;
			burnQ    <= 1'b0;
			loadQ    <= 1'b0;
			tempLowQ <= bsn_pkg::TEMP_LO_RST;
		end else if (clkEn) begin
			forceQ   <= forceD;
			unlockQ  <= unlockD;
			burnQ    <= burnD;
			loadQ    <= loadD;
			tempLowQ <= tempLowD;
		end
	end

	// shadow bytes: a finished load beats a host write in the same cycle
	for (genvar g = 0; g < bsn_pkg::SHADOW_COUNT; g++) begin : gShadow
		always_comb begin
			shadowD[g] = shadowQ[g];
			if (nif.loadDone) begin
				shadowD[g] = nif.loadData[g*8 +: 8]; // R8 R13
			end else if (wr && regAddr[7:3] == bsn_pkg::ADDR_SHADOW_HI5
				&& regAddr[2:0] == 3'(g)) begin
				shadowD[g] = regWdata; // R11
			end
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				shadowQ[g] <= bsn_pkg::SHADOW_RST; // R12
			end else if (clkEn) begin
				shadowQ[g] <= shadowD[g];
			end
		end
		// outputs follow the shadow byte directly, no burn needed
		assign cfgImage[g*8 +: 8] = shadowQ[g]; // R11
	end

	// read mux; unmapped addresses answer zero
	always_comb begin
		rdValue = 8'h00;
		if (regAddr == bsn_pkg::ADDR_IDENT) begin
			rdValue = IDENT_VALUE;
		end else if (regAddr == bsn_pkg::ADDR_FORCE) begin
			rdValue = {2'h0, forceQ};
		end else if (regAddr == bsn_pkg::ADDR_TEMP_HI) begin
			rdValue = tempHiNow; // R2
		end else if (regAddr == bsn_pkg::ADDR_TEMP_LO) begin
			rdValue = {tempLowQ, 5'h00}; // R2
		end else if (regAddr == bsn_pkg::ADDR_NVM_CTL) begin
			rdValue = {!nif.busy, 4'h0, unlockQ, burnQ, loadQ}; // R5
		end else if (regAddr[7:3] == bsn_pkg::ADDR_SHADOW_HI5) begin
			rdValue = shadowQ[regAddr[2:0]];
		end
	end

	// read data and led drive registered; data stands one cycle only
	always_comb begin
		rdDataD   = rd ? rdValue : bsn_pkg::RDATA_IDLE;
		ledDriveD = forceQ | pwmIn; // R1
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdDataQ   <= bsn_pkg::RDATA_IDLE;
			ledDriveQ <= 6'h00;
		end else if (clkEn) begin
			rdDataQ   <= rdDataD;
			ledDriveQ <= ledDriveD;
		end
	end

	assign regRdata = rdDataQ;
	assign ledDrive = ledDriveQ;
	assign nvmIdle  = !nif.busy; // R5

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence seqArmedBurn;
		clkEn && ctlWr && regWdata[bsn_pkg::BURN_POS] && unlockQ && nvmIdle;
	endsequence

	sequence seqLockedReq;
		clkEn && ctlWr && !unlockQ && nvmIdle
			&& (regWdata[bsn_pkg::BURN_POS] || regWdata[bsn_pkg::LOAD_POS]);
	endsequence

	sequence seqHighRead;
		rd && regAddr == bsn_pkg::ADDR_TEMP_HI;
	endsequence

	chk_force_drive: assert property ( // R1
		clkEn |=> ledDrive == ($past(forceQ) | $past(pwmIn)))
		else $error("led drive does not follow force and pwm");

	chk_temp_high: assert property ( // R2
		seqHighRead |=> regRdata == $past(tempHiNow))
		else $error("high temperature byte wrong");

	chk_temp_pair: assert property ( // R3
		seqHighRead ##1 (rd && regAddr == bsn_pkg::ADDR_TEMP_LO)
		|=> regRdata[7:5] == $past(tempLoNow, 2))
		else $error("low temperature bits not from latched sample");

	chk_ready_flag: assert property ( // R5
		(rd && regAddr == bsn_pkg::ADDR_NVM_CTL)
		|=> regRdata[bsn_pkg::NVM_IDLE_POS] == $past(nvmIdle))
		else $error("ready bit does not match store state");

	chk_burn_start: assert property ( // R7
		seqArmedBurn |=> !nvmIdle)
		else $error("armed burn did not start");

	chk_load_copy: assert property ( // R8
		(clkEn && nif.loadDone) |=> cfgImage == $past(nif.loadData))
		else $error("load did not refresh shadow bytes");

	chk_shadow_live: assert property ( // R11
		(wr && regAddr == {bsn_pkg::ADDR_SHADOW_HI5, 3'h0} && !nif.loadDone)
		|=> cfgImage[7:0] == $past(regWdata))
		else $error("shadow write not effective at once");

	chk_boot_load: assert property ( // R13
		($past(sys_rst) && clkEn) |-> !nvmIdle ##1 nif.loadDone)
		else $error("no load after reset");

	chk_locked_ignore: assert property ( // R14
		seqLockedReq |=> nvmIdle)
		else $error("request without unlock was not ignored");
endmodule
`default_nettype wire

// >>> bsn_pkg.sv
`default_nettype none
package bsn_pkg;
	// register offsets
	localparam logic [7:0] ADDR_IDENT       = 8'h03;
	localparam logic [7:0] ADDR_FORCE       = 8'h04;
	localparam logic [7:0] ADDR_TEMP_HI     = 8'h05;
	localparam logic [7:0] ADDR_TEMP_LO     = 8'h06;
	localparam logic [7:0] ADDR_NVM_CTL     = 8'h72;
	localparam logic [4:0] ADDR_SHADOW_HI5  = 5'h14; // a0h..a7h share top bits
	localparam int         SHADOW_COUNT     = 8;
	localparam int         IMAGE_W          = 64;

	// field positions and widths
	localparam int         FORCE_W          = 6;
	localparam int         TEMP_W           = 11;
	localparam int         TEMP_HI_LSB      = 3;
	localparam int         TEMP_LO_W        = 3;
	localparam int         NVM_IDLE_POS     = 7;
	localparam int         UNLOCK_POS       = 2;
	localparam int         BURN_POS         = 1;
	localparam int         LOAD_POS         = 0;

	// reset values
	localparam logic [5:0] FORCE_RST        = 6'h00;
	localparam logic [2:0] TEMP_LO_RST      = 3'h0;
	localparam logic [7:0] SHADOW_RST       = 8'h00;
	localparam logic [7:0] NVM_ERASED       = 8'h00;
	localparam logic [7:0] RDATA_IDLE       = 8'h00;

	// timing: one burn or load operation
	localparam longint unsigned NVM_OP_MS   = 200;
	localparam longint unsigned CLK_HZ      = 40000000;
	localparam longint unsigned MS_PER_S    = 1000;
	localparam int unsigned NVM_OP_CYCLES   =
		32'(NVM_OP_MS * CLK_HZ / MS_PER_S);

	// sequencer states of the non-volatile store
	typedef enum logic [1:0] {
		ST_BOOT,
		ST_IDLE,
		ST_BURN,
		ST_LOAD
	} bsn_nvm_state_e;
endpackage
`default_nettype wire

// >>> bsn_nvm_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bsn_nvm_if;
	logic        startBurn; // pulse: copy image into store
	logic        startLoad; // pulse: fetch store contents
	logic [63:0] image;     // live shadow contents
	logic [63:0] loadData;  // store contents, entry 0 in low byte
	logic        loadDone;  // pulse: loadData to be copied now
	logic        busy;      // operation running

	modport ctrl (
		output startBurn,
		output startLoad,
		output image,
		input  loadData,
		input  loadDone,
		input  busy
	);

	modport store (
		input  startBurn,
		input  startLoad,
		input  image,
		output loadData,
		output loadDone,
		output busy
	);
endinterface
`default_nettype wire

// >>> bsn_nvm_store.sv
`timescale 1ns/10ps
`default_nettype none
module bsn_nvm_store #(
	parameter int unsigned OP_CYCLES = bsn_pkg::NVM_OP_CYCLES
) (
	input  wire logic  clk,     // system clock
	input  wire logic  sys_rst, // sync reset, active high
	input  wire logic  clkEn,   // freezes all state when low
	bsn_nvm_if.store   nif      // link to the register bank
);
	bsn_pkg::bsn_nvm_state_e stateQ, stateD;
	logic [31:0]             cntQ, cntD;
	logic [63:0]             imgQ, imgD;
	logic                    loadDoneQ, loadDoneD;
	logic                    memWe;
	// contents survive sys_rst, only a burn changes them
	logic [7:0] memQ [bsn_pkg::SHADOW_COUNT] =
		'{default: bsn_pkg::NVM_ERASED};
	logic [7:0] memD [bsn_pkg::SHADOW_COUNT];

	// sequencer next state; burn snapshots the image at its start
	always_comb begin
		stateD    = stateQ;
		cntD      = cntQ;
		imgD      = imgQ;
		loadDoneD = 1'b0;
		memWe     = 1'b0;
		case (stateQ)
			bsn_pkg::ST_BOOT: begin
				loadDoneD = 1'b1; // R13
				stateD    = bsn_pkg::ST_IDLE;
			end
			bsn_pkg::ST_IDLE: begin
				if (nif.startBurn) begin
					stateD = bsn_pkg::ST_BURN; // R7
					cntD   = OP_CYCLES - 32'd1;
					imgD   = nif.image;
				end else if (nif.startLoad) begin
					stateD = bsn_pkg::ST_LOAD; // R8
					cntD   = OP_CYCLES - 32'd1;
				end
			end
			bsn_pkg::ST_BURN: begin
				if (cntQ == 32'd0) begin
					memWe  = 1'b1; // R7
					stateD = bsn_pkg::ST_IDLE;
				end else begin
					cntD = cntQ - 32'd1;
				end
			end
			default: begin
				if (cntQ == 32'd0) begin
					loadDoneD = 1'b1; // R8
					stateD    = bsn_pkg::ST_IDLE;
				end else begin
					cntD = cntQ - 32'd1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stateQ    <= bsn_pkg::ST_BOOT;
			cntQ      <= 32'h0000_0000;
			imgQ      <= 64'h0;
			loadDoneQ <= 1'b0;
		end else if (clkEn) begin
			stateQ    <= stateD;
			cntQ      <= cntD;
			imgQ      <= imgD;
			loadDoneQ <= loadDoneD;
		end
	end

	// one entry per shadow byte
	for (genvar g = 0; g < bsn_pkg::SHADOW_COUNT; g++) begin : gEntry
		always_comb begin
			memD[g] = memWe ? imgQ[g*8 +: 8] : memQ[g];
		end
		always_ff @(posedge clk) begin
			if (clkEn) begin
				memQ[g] <= memD[g];
			end
		end
		assign nif.loadData[g*8 +: 8] = memQ[g];
	end

	// busy covers the copy cycle too, so ready rises with fresh data
	assign nif.busy     = (stateQ != bsn_pkg::ST_IDLE) | loadDoneQ;
	assign nif.loadDone = loadDoneQ;

	chk_burn_commit: assert property ( // R7
		@(posedge clk) disable iff (sys_rst)
		(clkEn && memWe) |=> (nif.loadData == $past(imgQ)))
		else $error("burn did not commit the captured image");
endmodule
`default_nettype wire

// >>> bsn_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// bus master in place of the serial-bus host
module bsn_host_model (
	input  wire logic       clk,      // system clock
	output logic      [7:0] regAddr,  // register address
	output logic      [7:0] regWdata, // write data
	output logic            regWr,    // write strobe
	output logic            regRd,    // read strobe
	input  wire logic [7:0] regRdata  // read data
);
	// idle bus at time zero
	initial begin
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// released lines show inverted values, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		regAddr <= ~a;
		#1 d = regRdata;
	endtask

	// back-to-back reads, strobe held high across both
	task automatic rd2(input logic [7:0] a1, input logic [7:0] a2,
		output logic [7:0] d1, output logic [7:0] d2);
		@(posedge clk);
		regAddr <= a1;
		regRd <= 1'b1;
		@(posedge clk);
		regAddr <= a2;
		#1 d1 = regRdata;
		@(posedge clk);
		regRd <= 1'b0;
		regAddr <= ~a2;
		#1 d2 = regRdata;
	endtask

	// enable, unlock, then start; the caller does the wait
	task automatic nvm_op(input logic [7:0] op);
		wr(8'h01, 8'h05);
		wr(8'h72, 8'h04);
		wr(8'h72, op);
	endtask

	// closing write after the operation
	task automatic nvm_end();
		wr(8'h72, 8'h00);
	endtask
endmodule
`default_nettype wire

// >>> backlight_status_nvm_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module backlight_status_nvm_regs_tb_top;
	localparam int unsigned OPS   = 10;
	localparam logic [7:0]  IDENT = 8'h3c; // arbitrary value
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clkEn = 1'b1;
	logic [10:0] tempSample = 11'h000;
	logic [5:0]  pwmIn = 6'h00;
	logic [7:0]  regAddr, regWdata, regRdata, rv, rv2;
	logic        regWr, regRd, nvmIdle;
	logic [5:0]  ledDrive;
	logic [63:0] cfgImage;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          n;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	bsn_host_model i_host (.clk(clk), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata));

	bsn_regs #(.NVM_OP_CYCLES(OPS), .IDENT_VALUE(IDENT)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .tempSample(tempSample),
		.pwmIn(pwmIn), .ledDrive(ledDrive), .cfgImage(cfgImage),
		.nvmIdle(nvmIdle));

	task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rchk(string what, logic [7:0] a, logic [7:0] exp);
		i_host.rd(a, rv);
		chk(what, rv, exp);
	endtask

	// bounded wait; n counts the busy cycles seen
	task automatic wait_idle();
		n = 0;
		while (nvmIdle !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk("idle in time", nvmIdle, 1'b1);
	endtask

	// shadow image with byte i equal to base plus i
	function automatic logic [63:0] img(logic [7:0] base);
		for (int i = 0; i < 8; i++)
			img[i*8 +: 8] = base + 8'(i);
	endfunction

	task automatic fill(logic [7:0] base);
		for (int i = 0; i < 8; i++)
			i_host.wr(8'ha0 + 8'(i), base + 8'(i));
	endtask

	task automatic t_reset();
		wait_idle();
		chk("ready after boot", nvmIdle, 1'b1);
		chk("image after boot", cfgImage, 64'h0);
		chk("idle read data", regRdata, 8'h00);
		rchk("identity", 8'h03, IDENT);
		i_host.wr(8'h03, 8'hff);
		rchk("identity kept", 8'h03, IDENT);
		rchk("force reset", 8'h04, 8'h00);
		rchk("control reset", 8'h72, 8'h80);
		rchk("unmapped", 8'h5a, 8'h00);
	endtask

	task automatic t_force();
		@(posedge clk) pwmIn <= 6'h05;
		i_host.wr(8'h04, 8'h2a);
		repeat (2) @(posedge clk);
		#1 chk("led drive", ledDrive, 6'h2f);
		rchk("force readback", 8'h04, 8'h2a);
		// clock enable low: no write lands, drive holds
		@(posedge clk) begin
			clkEn <= 1'b0;
			pwmIn <= 6'h10;
		end
		i_host.wr(8'h04, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("frozen drive", ledDrive, 6'h2f);
		@(posedge clk) begin
			clkEn <= 1'b1;
			pwmIn <= 6'h00;
		end
		rchk("frozen force", 8'h04, 8'h2a);
	endtask

	// later reads see the latched low bits, not the live ones
	task automatic t_temp();
		@(posedge clk) tempSample <= 11'h5a3;
		rchk("temp high", 8'h05, 8'hb4);
		@(posedge clk) tempSample <= 11'h000;
		rchk("temp low", 8'h06, 8'h60);
		// live low bits drop to zero between the two strobes
		@(posedge clk) tempSample <= 11'h2c6;
		fork
			i_host.rd2(8'h05, 8'h06, rv, rv2);
			begin
				repeat (2) @(posedge clk);
				tempSample <= 11'h000;
			end
		join
		chk("temp high b2b", rv, 8'h58);
		chk("temp low b2b", rv2, 8'hc0);
	endtask

	task automatic t_shadow();
		fill(8'h10);
		@(posedge clk);
		#1 chk("shadow live", cfgImage, img(8'h10));
		rchk("shadow read", 8'ha3, 8'h13);
	endtask

	task automatic t_locked();
		i_host.wr(8'h72, 8'h02);
		repeat (3) @(posedge clk);
		#1 chk("burn locked", nvmIdle, 1'b1);
		rchk("control bits", 8'h72, 8'h82);
		i_host.wr(8'h72, 8'h01);
		repeat (3) @(posedge clk);
		#1 chk("load locked", nvmIdle, 1'b1);
		// unlock in the same write does not arm it
		i_host.wr(8'h72, 8'h06);
		repeat (3) @(posedge clk);
		#1 chk("same write locked", nvmIdle, 1'b1);
		i_host.wr(8'h72, 8'h00);
	endtask

	// burn 10h image, spoil shadows, load it back
	task automatic t_burn_load();
		i_host.nvm_op(8'h02);
		@(posedge clk);
		#1 chk("busy in burn", nvmIdle, 1'b0);
		rchk("ready bit low", 8'h72, 8'h02);
		wait_idle();
		// three busy cycles pass before the wait starts counting
		chk("burn length", n, OPS - 3);
		chk("ready after burn", nvmIdle, 1'b1);
		i_host.nvm_end();
		fill(8'h60);
		i_host.nvm_op(8'h01);
		@(posedge clk);
		#1 chk("busy in load", nvmIdle, 1'b0);
		wait_idle();
		chk("load length", n, OPS);
		chk("image loaded", cfgImage, img(8'h10));
		i_host.nvm_end();
	endtask

	// unburned shadows vanish; stored image returns at boot
	task automatic t_reboot();
		fill(8'h60);
		@(posedge clk) sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		wait_idle();
		chk("image reboot", cfgImage, img(8'h10));
		rchk("shadow reboot", 8'ha0, 8'h10);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_force();
		t_temp();
		t_shadow();
		t_locked();
		t_burn_load();
		t_reboot();
		results();
	end

	// the run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
